// file: include/gecd_pkg.sv
// gecd_pkg: constants and types of the guest exit control decoder
package gecd_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_ASYNC_CTL   = 8'h00;
    localparam logic [7:0] OFF_INSTR_CTL   = 8'h04;
    localparam logic [7:0] OFF_SECOND_CTL  = 8'h08;
    localparam logic [7:0] OFF_ASYNC_CAP   = 8'h0c;
    localparam logic [7:0] OFF_ASYNC_TCAP  = 8'h10;
    localparam logic [7:0] OFF_TIMER_LOAD  = 8'h14;
    localparam logic [7:0] OFF_TS_OFFSET   = 8'h18;
    localparam logic [7:0] OFF_STATUS      = 8'h1c;

    // ------------------------------------------------------------
    // async (pin) control bit positions
    // ------------------------------------------------------------
    localparam int A_EXT_INTR = 0;
    localparam int A_NMI_EXIT = 3;
    localparam int A_VNMI     = 5;
    localparam int A_TIMER    = 6;

    // ------------------------------------------------------------
    // instruction (primary) control bit positions
    // ------------------------------------------------------------
    localparam int I_INTR_WIN = 2;
    localparam int I_TS_OFFS  = 3;
    localparam int I_HALT     = 7;
    localparam int I_PG_INV   = 9;
    localparam int I_MONITOR_WAIT_INSTR    = 10;
    localparam int I_PMC_RD   = 11;
    localparam int I_TS_RD    = 12;
    localparam int I_PTB_WR   = 15;
    localparam int I_PTB_RD   = 16;
    localparam int I_TPR_WR   = 19;

    // ------------------------------------------------------------
    // capability masks and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] ASYNC_FIXED1     = 32'h0000_0016;
    localparam logic [31:0] ASYNC_ALLOWED1   = 32'h0000_007f;
    localparam logic [31:0] ASYNC_TRUE_FIX1  = 32'h0000_0000;
    localparam logic [31:0] INSTR_FIXED1     = 32'h0401_e172;
    localparam logic [31:0] INSTR_ALLOWED1   = 32'h0409_fffe;
    localparam logic [31:0] CTL_RESET        = 32'h0000_0000;

    typedef enum logic [3:0] {
        INSTR_NONE, INSTR_HALT, INSTR_PG_INV, INSTR_MONITOR_WAIT_INSTR, INSTR_PMC_RD,
        INSTR_TS_RD, INSTR_TS_RD_ID, INSTR_MREG_TS_RD, INSTR_PTB_WR,
        INSTR_PTB_RD, INSTR_TPR_WR, INSTR_OTHER
    } gecd_instr_t;

    typedef enum logic [3:0] {
        RSN_NONE, RSN_NMI, RSN_EXT_INTR, RSN_TIMER, RSN_INTR_WIN,
        RSN_HALT, RSN_PG_INV, RSN_MONITOR_WAIT_INSTR, RSN_PMC_RD, RSN_TS_RD,
        RSN_PTB_WR, RSN_PTB_RD, RSN_TPR_WR
    } gecd_reason_t;

endpackage : gecd_pkg

// file: hdl/gecd_top.sv
// gecd_top: guest exit decision logic with its apb control registers
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
module gecd_top #(
    parameter logic HAS_64BIT = 1'b1
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 entry_req,
    input  wire logic                 ext_intr,
    input  wire logic                 nmi,
    input  wire logic                 guest_interrupt_flag,
    input  wire logic                 other_intr_block,
    input  wire logic                 interrupt_return,
    input  wire logic                 vnmi_inject,
    input  wire logic                 instr_start,
    input  wire gecd_pkg::gecd_instr_t instr,
    input  wire logic                 ptb_target_hit,
    input  wire logic [31:0]          time_stamp_counter,
    output logic                      in_guest,
    output logic                      guest_exit,
    output gecd_pkg::gecd_reason_t    exit_reason,
    output logic                      entry_fail,
    output logic                      intr_deliver,
    output logic                      nmi_deliver,
    output logic                      nmi_block_state,
    output logic                      ts_valid,
    output logic      [31:0]          ts_value
);
    import gecd_pkg::*;

    typedef struct packed {
        logic [31:0]  actl;
        logic [31:0]  ictl;
        logic [31:0]  sctl;
        logic [31:0]  tload;
        logic [31:0]  tsoff;
        logic [31:0]  timer;
        logic         guest;
        logic         nmi_blk;
        logic         vnmi_blk;
        logic         exit_p;
        gecd_reason_t reason;
        logic         efail;
        logic         idel;
        logic         ndel;
        logic         nbs;
        logic         tsv;
        logic [31:0]  tsval;
        logic [31:0]  rdata;
        logic         rdy;
        logic         err;
    } gecd_state_t;

    gecd_state_t st_r;
    gecd_state_t st_nxt;

    logic         setup;
    logic         wr_acc;
    logic         mapped;
    logic         ro_hit;
    logic [31:0]  rd_mux;
    logic         entry_ok;
    logic         nmi_real_blk;
    gecd_reason_t ev;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite && st_r.rdy && !st_r.err;
    assign ro_hit = (paddr == OFF_ASYNC_CAP) || (paddr == OFF_ASYNC_TCAP)
                 || (paddr == OFF_STATUS);

    always_comb begin
        mapped = 1'b1;
        unique case (paddr)
            OFF_ASYNC_CTL:  rd_mux = st_r.actl;
            OFF_INSTR_CTL:  rd_mux = st_r.ictl;
            OFF_SECOND_CTL: rd_mux = st_r.sctl;
            // default register: bits 1,2,4 always must be one
            OFF_ASYNC_CAP:  rd_mux = ASYNC_FIXED1;
            // alternate register: zero settings allowed here
            OFF_ASYNC_TCAP: rd_mux = ASYNC_TRUE_FIX1;
            OFF_TIMER_LOAD: rd_mux = st_r.tload;
            OFF_TS_OFFSET:  rd_mux = st_r.tsoff;
            OFF_STATUS:     rd_mux = {st_r.timer[23:0], st_r.reason,
                                      st_r.vnmi_blk, st_r.nmi_blk,
                                      st_r.efail, st_r.guest};
            default: begin
                rd_mux = 32'h0000_0000;
                mapped = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // entry checks
    // ------------------------------------------------------------
    // actl against the alternate mask, so zero settings of 1,2,4 pass
    always_comb begin
        entry_ok = ((st_r.actl & ASYNC_TRUE_FIX1) == ASYNC_TRUE_FIX1)
                && ((st_r.actl & ~ASYNC_ALLOWED1) == 32'h0000_0000)
                && ((st_r.ictl & INSTR_FIXED1) == INSTR_FIXED1)
                && ((st_r.ictl & ~INSTR_ALLOWED1) == 32'h0000_0000);
        if (st_r.actl[A_VNMI] && !st_r.actl[A_NMI_EXIT]) begin
            entry_ok = 1'b0;
        end
        if (!HAS_64BIT && st_r.ictl[I_TPR_WR]) begin
            entry_ok = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // event priority: nmi, interrupt, timer, window, instruction
    // ------------------------------------------------------------
    // with virtual nmis real blocking never applies
    assign nmi_real_blk = st_r.nmi_blk && !st_r.actl[A_VNMI];

    always_comb begin
        ev = RSN_NONE;
        if (nmi && st_r.actl[A_NMI_EXIT]) begin
            ev = RSN_NMI;
        end else if (ext_intr && st_r.actl[A_EXT_INTR]
                     && !other_intr_block) begin
            // interrupt flag deliberately not consulted
            ev = RSN_EXT_INTR;
        end else if (st_r.actl[A_TIMER] && st_r.timer == 32'h0000_0000) begin
            ev = RSN_TIMER;
        end else if (instr_start) begin
            if (st_r.ictl[I_INTR_WIN] && guest_interrupt_flag
                && !other_intr_block) begin
                ev = RSN_INTR_WIN;
            end else begin
                unique case (instr)
                    INSTR_HALT:
                        if (st_r.ictl[I_HALT]) ev = RSN_HALT;
                    INSTR_PG_INV:
                        if (st_r.ictl[I_PG_INV]) ev = RSN_PG_INV;
                    INSTR_MONITOR_WAIT_INSTR:
                        if (st_r.ictl[I_MONITOR_WAIT_INSTR]) ev = RSN_MONITOR_WAIT_INSTR;
                    INSTR_PMC_RD:
                        if (st_r.ictl[I_PMC_RD]) ev = RSN_PMC_RD;
                    INSTR_TS_RD, INSTR_TS_RD_ID:
                        if (st_r.ictl[I_TS_RD]) ev = RSN_TS_RD;
                    INSTR_PTB_WR:
                        if (st_r.ictl[I_PTB_WR] && !ptb_target_hit)
                            ev = RSN_PTB_WR;
                    INSTR_PTB_RD:
                        if (st_r.ictl[I_PTB_RD]) ev = RSN_PTB_RD;
                    INSTR_TPR_WR:
                        if (st_r.ictl[I_TPR_WR]) ev = RSN_TPR_WR;
                    default: ev = RSN_NONE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt        = st_r;
        st_nxt.exit_p = 1'b0;
        st_nxt.efail  = 1'b0;
        st_nxt.idel   = 1'b0;
        st_nxt.ndel   = 1'b0;
        st_nxt.tsv    = 1'b0;
        st_nxt.rdy    = setup;
        st_nxt.err    = setup && (!mapped || (pwrite && ro_hit));
        if (setup) begin
            st_nxt.rdata = pwrite ? 32'h0000_0000 : rd_mux;
        end
        if (wr_acc) begin
            unique case (paddr)
                OFF_ASYNC_CTL:  st_nxt.actl  = pwdata;
                OFF_INSTR_CTL:  st_nxt.ictl  = pwdata;
                OFF_SECOND_CTL: st_nxt.sctl  = pwdata;
                OFF_TIMER_LOAD: st_nxt.tload = pwdata;
                OFF_TS_OFFSET:  st_nxt.tsoff = pwdata;
                default: ;
            endcase
        end
        if (!st_r.guest) begin
            if (entry_req) begin
                st_nxt.guest = entry_ok;
                st_nxt.efail = !entry_ok;
                st_nxt.timer = st_r.tload;
                st_nxt.reason = RSN_NONE;
            end
        end else if (ev != RSN_NONE) begin
            st_nxt.guest  = 1'b0;
            st_nxt.exit_p = 1'b1;
            st_nxt.reason = ev;
        end else begin
            // nothing exits: normal guest semantics apply
            if (st_r.actl[A_TIMER]) begin
                st_nxt.timer = st_r.timer - 32'h0000_0001;
            end
            if (nmi && !nmi_real_blk) begin
                st_nxt.ndel = 1'b1;
                st_nxt.nmi_blk = !st_r.actl[A_VNMI];
            end else if (ext_intr && guest_interrupt_flag
                         && !other_intr_block) begin
                st_nxt.idel = 1'b1;
            end
            if (instr_start && (instr == INSTR_TS_RD
                || instr == INSTR_TS_RD_ID || instr == INSTR_MREG_TS_RD)) begin
                st_nxt.tsv   = 1'b1;
                st_nxt.tsval = time_stamp_counter
                    + (st_r.ictl[I_TS_OFFS] ? st_r.tsoff : 32'h0000_0000);
            end
        end
        if (vnmi_inject && st_r.actl[A_VNMI]) begin
            st_nxt.vnmi_blk = 1'b1;
        end
        // return ends whichever blocking the mode tracks
        if (st_r.guest && interrupt_return) begin
            if (st_r.actl[A_VNMI]) begin
                st_nxt.vnmi_blk = 1'b0;
            end else begin
                st_nxt.nmi_blk = 1'b0;
            end
        end
        // interruptibility bit 3 view: virtual blocking when enabled
        st_nxt.nbs = st_nxt.actl[A_VNMI] ? st_nxt.vnmi_blk
                                         : st_nxt.nmi_blk;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{actl: CTL_RESET, ictl: CTL_RESET, sctl: CTL_RESET,
                      tload: 32'h0000_0000, tsoff: 32'h0000_0000,
                      timer: 32'h0000_0000, reason: RSN_NONE,
                      tsval: 32'h0000_0000, rdata: 32'h0000_0000,
                      default: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata          = st_r.rdata;
    assign pready          = st_r.rdy;
    assign pslverr         = st_r.err;
    assign in_guest        = st_r.guest;
    assign guest_exit      = st_r.exit_p;
    assign exit_reason     = st_r.reason;
    assign entry_fail      = st_r.efail;
    assign intr_deliver    = st_r.idel;
    assign nmi_deliver     = st_r.ndel;
    assign nmi_block_state = st_r.nbs;
    assign ts_valid        = st_r.tsv;
    assign ts_value        = st_r.tsval;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_ext_exit;
        @(posedge pclk) disable iff (!presetn)
        st_r.guest && ext_intr && !nmi && st_r.actl[A_EXT_INTR]
            && !other_intr_block
        |=> guest_exit && exit_reason == RSN_EXT_INTR && !in_guest;
    endproperty
    a_ext_exit: assert property (p_ext_exit)
        else $error("external interrupt did not exit");

    property p_if_ignored;
        @(posedge pclk) disable iff (!presetn)
        st_r.actl[A_EXT_INTR] && ext_intr |=> !intr_deliver;
    endproperty
    a_if_ignored: assert property (p_if_ignored)
        else $error("interrupt delivered while exiting enabled");

    property p_nmi_exit;
        @(posedge pclk) disable iff (!presetn)
        st_r.guest && nmi && st_r.actl[A_NMI_EXIT]
        |=> guest_exit && exit_reason == RSN_NMI && !nmi_deliver;
    endproperty
    a_nmi_exit: assert property (p_nmi_exit)
        else $error("nmi did not exit");

    property p_vnmi_noblk;
        @(posedge pclk) disable iff (!presetn)
        st_r.actl[A_VNMI] |-> !nmi_real_blk;
    endproperty
    a_vnmi_noblk: assert property (p_vnmi_noblk)
        else $error("nmi blocked under virtual nmis");

    property p_timer_zero;
        @(posedge pclk) disable iff (!presetn)
        st_r.guest && st_r.actl[A_TIMER] && st_r.timer == 32'h0000_0000
        |=> guest_exit;
    endproperty
    a_timer_zero: assert property (p_timer_zero)
        else $error("timer reached zero without exit");

    property p_timer_dec;
        @(posedge pclk) disable iff (!presetn)
        st_r.guest && !st_nxt.exit_p && st_r.actl[A_TIMER]
        |=> st_r.timer == $past(st_r.timer) - 32'h0000_0001;
    endproperty
    a_timer_dec: assert property (p_timer_dec)
        else $error("timer did not count down");

    property p_entry_fail;
        @(posedge pclk) disable iff (!presetn)
        !st_r.guest && entry_req && st_r.actl[A_VNMI]
            && !st_r.actl[A_NMI_EXIT]
        |=> entry_fail && !in_guest;
    endproperty
    a_entry_fail: assert property (p_entry_fail)
        else $error("bad controls entered guest");

    property p_halt_exit;
        @(posedge pclk) disable iff (!presetn)
        st_r.guest && instr_start && instr == INSTR_HALT
            && st_r.ictl[I_HALT] && st_nxt.reason == RSN_HALT
        |=> guest_exit ##1 !guest_exit;
    endproperty
    a_halt_exit: assert property (p_halt_exit)
        else $error("halt exit not a single pulse");

    property p_no_exit_clear;
        @(posedge pclk) disable iff (!presetn)
        st_r.guest && instr_start && !nmi && !ext_intr
            && !st_r.actl[A_TIMER] && !st_r.ictl[I_INTR_WIN]
            && instr == INSTR_MONITOR_WAIT_INSTR && !st_r.ictl[I_MONITOR_WAIT_INSTR]
        |=> in_guest && !guest_exit;
    endproperty
    a_no_exit_clear: assert property (p_no_exit_clear)
        else $error("exit with control clear");

    property p_ts_offset;
        @(posedge pclk) disable iff (!presetn)
        ts_valid |-> ts_value == $past(time_stamp_counter)
            + ($past(st_r.ictl[I_TS_OFFS]) ? $past(st_r.tsoff)
                                            : 32'h0000_0000);
    endproperty
    a_ts_offset: assert property (p_ts_offset)
        else $error("time-stamp value wrong");

    c_entry: cover property (@(posedge pclk) disable iff (!presetn)
        !in_guest ##1 in_guest);
    c_timer: cover property (@(posedge pclk) disable iff (!presetn)
        guest_exit && exit_reason == RSN_TIMER);
    c_window: cover property (@(posedge pclk) disable iff (!presetn)
        guest_exit && exit_reason == RSN_INTR_WIN);
    c_fail: cover property (@(posedge pclk) disable iff (!presetn)
        entry_fail);

endmodule : gecd_top

// file: test/tb_top.sv
// tb_top: self-checking bench for the guest exit control decoder
`timescale 1ns/1ps
module tb_top;
    import gecd_pkg::*;
    // ------------------------------------------------------------
    // clock, reset and design signals
    // ------------------------------------------------------------
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, time_stamp_counter, ts_value, rd;
    logic        pready, pslverr, entry_req, ext_intr, nmi, err;
    logic        guest_interrupt_flag, other_intr_block, interrupt_return;
    logic        vnmi_inject, instr_start, ptb_target_hit, in_guest;
    logic        guest_exit, entry_fail, intr_deliver, nmi_deliver;
    logic        nmi_block_state, ts_valid;
    gecd_instr_t  instr;
    gecd_reason_t exit_reason;
    int          miscompares = 0;
    int          num_checks  = 0;
    int          n;
    gecd_instr_t  kinds [7] = '{INSTR_HALT, INSTR_PG_INV, INSTR_MONITOR_WAIT_INSTR,
        INSTR_PMC_RD, INSTR_TS_RD, INSTR_TS_RD_ID, INSTR_TPR_WR};
    int           bits  [7] = '{I_HALT, I_PG_INV, I_MONITOR_WAIT_INSTR, I_PMC_RD,
        I_TS_RD, I_TS_RD, I_TPR_WR};
    gecd_reason_t rsns  [7] = '{RSN_HALT, RSN_PG_INV, RSN_MONITOR_WAIT_INSTR,
        RSN_PMC_RD, RSN_TS_RD, RSN_TS_RD, RSN_TPR_WR};

    gecd_top gecd_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .entry_req(entry_req), .ext_intr(ext_intr), .nmi(nmi),
        .guest_interrupt_flag(guest_interrupt_flag),
        .other_intr_block(other_intr_block),
        .interrupt_return(interrupt_return), .vnmi_inject(vnmi_inject),
        .instr_start(instr_start), .instr(instr),
        .ptb_target_hit(ptb_target_hit),
        .time_stamp_counter(time_stamp_counter), .in_guest(in_guest),
        .guest_exit(guest_exit), .exit_reason(exit_reason),
        .entry_fail(entry_fail), .intr_deliver(intr_deliver),
        .nmi_deliver(nmi_deliver), .nmi_block_state(nmi_block_state),
        .ts_valid(ts_valid), .ts_value(ts_value));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // ------------------------------------------------------------
    // compare and bus tasks
    // ------------------------------------------------------------
    task automatic chk32(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk32
    task automatic chk1(input string nm, input logic e, g);
        chk32(nm, {31'h0, e}, {31'h0, g});
    endtask : chk1
    task automatic chk_rsn(input gecd_reason_t e);
        chk32("exit_reason", {28'h0, e}, {28'h0, exit_reason});
    endtask : chk_rsn
    // hold the request until pready is sampled high, bounded wait
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 16) begin
            k++;
            @(posedge pclk);
        end
        if (k == 16) chk1("pready wait", 1'b1, 1'b0);
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // launch an entry and let its result land
    task automatic go(input logic [31:0] a, p);
        apb(1'b1, OFF_ASYNC_CTL, a);
        apb(1'b1, OFF_INSTR_CTL, p);
        @(posedge pclk) entry_req <= 1'b1;
        @(posedge pclk) entry_req <= 1'b0;
        #1;
    endtask : go
    task automatic run_instr(input gecd_instr_t k);
        @(posedge pclk);
        instr_start <= 1'b1; instr <= k;
        @(posedge pclk) instr_start <= 1'b0;
        #1;
    endtask : run_instr
    // base-register read always exits, so it serves to leave the guest
    task automatic leave;
        if (in_guest === 1'b1) run_instr(INSTR_PTB_RD);
    endtask : leave
    task automatic report_and_stop;
        if (miscompares == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; entry_req = 1'b0; ext_intr = 1'b0;
        nmi = 1'b0; guest_interrupt_flag = 1'b0; other_intr_block = 1'b0;
        interrupt_return = 1'b0; vnmi_inject = 1'b0; instr_start = 1'b0;
        instr = INSTR_NONE; ptb_target_hit = 1'b0;
        time_stamp_counter = 32'h0000_0234;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_ASYNC_CTL, 32'h0); chk32("async rst", CTL_RESET, rd);
        apb(1'b0, OFF_INSTR_CTL, 32'h0); chk32("instr rst", CTL_RESET, rd);
        apb(1'b0, OFF_ASYNC_CAP, 32'h0); chk32("cap", 32'h16, rd);
        apb(1'b0, OFF_ASYNC_TCAP, 32'h0); chk32("tcap", 32'h0, rd);
        apb(1'b1, OFF_ASYNC_CAP, 32'h0); chk1("cap ro", 1'b1, err);
        apb(1'b0, OFF_ASYNC_CAP, 32'h0); chk32("cap kept", 32'h16, rd);
        apb(1'b0, 8'h20, 32'h0); chk1("unmapped err", 1'b1, err);
        chk32("unmapped data", 32'h0, rd);
        apb(1'b1, OFF_ASYNC_CTL, 32'h8000_0069);
        apb(1'b0, OFF_ASYNC_CTL, 32'h0); chk32("async", 32'h8000_0069, rd);
        apb(1'b1, OFF_SECOND_CTL, 32'h0000_00a5);
        apb(1'b0, OFF_SECOND_CTL, 32'h0); chk32("second", 32'ha5, rd);
        // entries refused for bad reserved bits or lone virtual nmi
        go(32'h0, 32'h0); chk1("fail fixed", 1'b1, entry_fail);
        go(32'h80, INSTR_FIXED1); chk1("fail rsvd", 1'b1, entry_fail);
        go(32'h20, INSTR_FIXED1); chk1("fail vnmi", 1'b1, entry_fail);
        chk1("no guest", 1'b0, in_guest);
        // instruction exits with bit set, none with bit clear
        for (int i = 0; i < 7; i++) begin
            go(32'h0, INSTR_FIXED1 | (32'h1 << bits[i]));
            chk1("entered", 1'b1, in_guest);
            run_instr(kinds[i]);
            chk1("instr exit", 1'b1, guest_exit);
            chk_rsn(rsns[i]);
            go(32'h0, INSTR_FIXED1);
            run_instr(kinds[i]);
            chk1("no instr exit", 1'b0, guest_exit);
            leave();
        end
        apb(1'b0, OFF_STATUS, 32'h0);
        chk32("status reason", {28'h0, RSN_PTB_RD}, {28'h0, rd[7:4]});
        // base write exits unless a target matches
        go(32'h0, INSTR_FIXED1);
        @(posedge pclk) ptb_target_hit <= 1'b1;
        run_instr(INSTR_PTB_WR); chk1("ptb hit", 1'b0, guest_exit);
        @(posedge pclk) ptb_target_hit <= 1'b0;
        run_instr(INSTR_PTB_WR); chk_rsn(RSN_PTB_WR);
        // time-stamp offset on both read paths
        apb(1'b1, OFF_TS_OFFSET, 32'h0000_1000);
        go(32'h0, INSTR_FIXED1 | (32'h1 << I_TS_OFFS));
        run_instr(INSTR_TS_RD); chk32("ts offs", 32'h1234, ts_value);
        chk1("ts valid", 1'b1, ts_valid);
        run_instr(INSTR_MREG_TS_RD); chk32("mreg offs", 32'h1234, ts_value);
        leave();
        go(32'h0, INSTR_FIXED1);
        run_instr(INSTR_TS_RD); chk32("ts plain", 32'h0234, ts_value);
        // external interrupt: exit ignores the flag, else normal delivery
        @(posedge pclk) ext_intr <= 1'b1;
        guest_interrupt_flag <= 1'b1;
        @(posedge pclk) ext_intr <= 1'b0;
        #1 chk1("intr deliver", 1'b1, intr_deliver);
        leave();
        go(32'h1, INSTR_FIXED1);
        @(posedge pclk) guest_interrupt_flag <= 1'b0;
        @(posedge pclk) ext_intr <= 1'b1;
        @(posedge pclk) ext_intr <= 1'b0;
        #1 chk_rsn(RSN_EXT_INTR);
        // interrupt window: flag set and no other blocking
        go(32'h0, INSTR_FIXED1 | (32'h1 << I_INTR_WIN));
        @(posedge pclk) guest_interrupt_flag <= 1'b1;
        other_intr_block <= 1'b1;
        run_instr(INSTR_OTHER); chk1("win blocked", 1'b0, guest_exit);
        @(posedge pclk) other_intr_block <= 1'b0;
        run_instr(INSTR_OTHER); chk_rsn(RSN_INTR_WIN);
        // nmi: delivery blocks until interrupt return, or exits
        go(32'h0, INSTR_FIXED1);
        @(posedge pclk) nmi <= 1'b1;
        @(posedge pclk) nmi <= 1'b0;
        #1 chk1("nmi deliver", 1'b1, nmi_deliver);
        @(posedge pclk) #1 chk1("nmi blocked", 1'b1, nmi_block_state);
        @(posedge pclk) interrupt_return <= 1'b1;
        @(posedge pclk) interrupt_return <= 1'b0;
        @(posedge pclk) #1 chk1("nmi unblock", 1'b0, nmi_block_state);
        leave();
        go(32'h3e, INSTR_FIXED1);
        chk1("vnmi entry", 1'b1, in_guest);
        @(posedge pclk) vnmi_inject <= 1'b1;
        @(posedge pclk) vnmi_inject <= 1'b0;
        @(posedge pclk) #1 chk1("vnmi block", 1'b1, nmi_block_state);
        @(posedge pclk) nmi <= 1'b1;
        @(posedge pclk) nmi <= 1'b0;
        #1 chk_rsn(RSN_NMI);
        // countdown timer reaches zero and exits
        apb(1'b1, OFF_TIMER_LOAD, 32'h8);
        go(32'h40, INSTR_FIXED1);
        n = 0;
        while (guest_exit !== 1'b1 && n < 40) begin
            @(posedge pclk) #1;
            n++;
        end
        chk32("timer span", 32'd9, n);
        chk_rsn(RSN_TIMER);
        report_and_stop();
    end
endmodule : tb_top
